// >>> scf_pkg.sv
package scf_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RES    = 8'h04;
  localparam logic [7:0] ADDR_CUR    = 8'h08;
  localparam logic [7:0] ADDR_IDLE   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_POS    = 8'h14;

  // Control register fields.
  localparam int CTRL_SW_MODE = 0;
  localparam int CTRL_DUAL    = 1;
  localparam int CTRL_FALLING = 2;

  // Idle register fields.
  localparam int IDLE_PCT_LSB = 0;
  localparam int IDLE_MS_LSB  = 16;

  // Reset values of the software settings.
  localparam logic [9:0]  RES_RST      = 10'h080;
  localparam logic [4:0]  CUR_RST      = 5'h0A;
  localparam logic [6:0]  PCT_RST      = 7'h3C;
  localparam logic [15:0] IDLE_MS_RST  = 16'h07D0;

  // Legal ranges; current is counted in tenths of an ampere.
  localparam logic [9:0]  RES_MIN      = 10'h001;
  localparam logic [9:0]  RES_MAX      = 10'h200;
  localparam logic [4:0]  CUR_MIN      = 5'h03;
  localparam logic [4:0]  CUR_MAX      = 5'h16;
  localparam logic [6:0]  PCT_FULL     = 7'h64;

  // Fixed switch resolutions, microsteps per full step.
  localparam logic [9:0]  RES_SW8      = 10'h008;
  localparam logic [9:0]  RES_SW16     = 10'h010;
  localparam logic [9:0]  RES_SW32     = 10'h020;

  // Blink counts per protection.
  localparam logic [2:0]  BLINK_OC     = 3'h1;
  localparam logic [2:0]  BLINK_OV     = 3'h2;
  localparam logic [2:0]  BLINK_PH     = 3'h4;

  // Timing: clock rate, frame, flash slot and settle figures; bus response codes.
  localparam int          CLK_HZ       = 25000000;
  localparam int          MS_PER_S     = 1000;
  localparam int          FRAME_S      = 3;
  localparam logic [11:0] FRAME_MS     = 12'(FRAME_S * MS_PER_S);
  localparam logic [8:0]  SLOT_MS      = 9'h190;
  localparam logic [8:0]  FLASH_ON_MS  = 9'h0C8;
  localparam logic [1:0]  CFG_SETTLE   = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// >>> scf_drive_ctrl.sv
`timescale 1ns/1ns
module scf_drive_ctrl #(
  parameter int MS_CYCLES = 25000       // Clock cycles in one millisecond.
) (
  input  wire logic        aclk,                      // System clock.
  input  wire logic        aresetn,                   // Synchronous reset.
  input  wire logic [7:0]  s_axi_awaddr,              // Write address.
  input  wire logic        s_axi_awvalid,             // Write address valid.
  output logic             s_axi_awready,             // Write address ready.
  input  wire logic [31:0] s_axi_wdata,               // Write data.
  input  wire logic [3:0]  s_axi_wstrb,               // Write byte lanes.
  input  wire logic        s_axi_wvalid,              // Write data valid.
  output logic             s_axi_wready,              // Write data ready.
  output logic [1:0]       s_axi_bresp,               // Write response.
  output logic             s_axi_bvalid,              // Write response valid.
  input  wire logic        s_axi_bready,              // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,              // Read address.
  input  wire logic        s_axi_arvalid,             // Read address valid.
  output logic             s_axi_arready,             // Read address ready.
  output logic [31:0]      s_axi_rdata,               // Read data.
  output logic [1:0]       s_axi_rresp,               // Read response.
  output logic             s_axi_rvalid,              // Read data valid.
  input  wire logic        s_axi_rready,              // Read data ready.
  input  wire logic        step_pulse_in,             // Step, or forward.
  input  wire logic        direction_in,              // Direction, or back.
  input  wire logic        drive_enable_in,           // High enables drive.
  input  wire logic        current_select_bit0,       // Current switch 0.
  input  wire logic        current_select_bit1,       // Current switch 1.
  input  wire logic        current_select_bit2,       // Current switch 2.
  input  wire logic        standstill_current_select, // Standstill switch.
  input  wire logic        resolution_select_bit0,    // Resolution switch 0.
  input  wire logic        resolution_select_bit1,    // Resolution switch 1.
  input  wire logic        over_current_in,           // Over-current sense.
  input  wire logic        over_voltage_in,           // Over-voltage sense.
  input  wire logic        phase_error_in,            // Phase fault sense.
  output logic             drive_active_out,          // Power stage on.
  output logic [4:0]       current_cmd_out,           // Current, 0.1 A units.
  output logic [9:0]       microstep_res_out,         // Microsteps per step.
  output logic             red_led_out                // Fault indicator.
);
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  // Switches read 1 when off, so the on position counts as zero.
  logic [11:0] pin_meta_r, pin_sync_r;
  logic [1:0]  edge_prev_r;
  logic [5:0]  sw_cfg_r;
  logic [1:0]  cfg_cnt_r;
  logic        cfg_valid_r;
  logic [2:0]  ctrl_r;
  logic [9:0]  res_r;
  logic [4:0]  cur_r;
  logic [6:0]  pct_r;
  logic [15:0] idle_ms_cfg_r;
  logic [2:0]  fault_r;
  logic [31:0] position_r;
  logic [15:0] pre_r;
  logic [15:0] idle_cnt_r;
  logic [11:0] frame_ms_r;
  logic [8:0]  slot_ms_r;
  logic [2:0]  slot_idx_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  function automatic logic act_edge(input logic cur, input logic prev,
                                    input logic falling);
    act_edge = falling ? (prev & ~cur) : (cur & ~prev);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Pins pass two flops; only the second stage is read by logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= 12'h000;
      pin_sync_r <= 12'h000;
    end else begin
      pin_meta_r <= {phase_error_in, over_voltage_in, over_current_in,
                     resolution_select_bit1, resolution_select_bit0,
                     standstill_current_select, current_select_bit2,
                     current_select_bit1, current_select_bit0,
                     drive_enable_in, direction_in, step_pulse_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire       s_step    = pin_sync_r[0];
  wire       s_dir     = pin_sync_r[1];
  wire       s_enable  = pin_sync_r[2];  // Pull-up keeps an open pin high.
  wire [2:0] s_faults  = pin_sync_r[11:9];

  // Switch bank is caught once, after the synchronisers have settled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_cnt_r   <= 2'h0;
      cfg_valid_r <= 1'b0;
      sw_cfg_r    <= 6'h00;
    end else if (!cfg_valid_r) begin
      cfg_cnt_r <= cfg_cnt_r + 2'h1;
      if (cfg_cnt_r == scf_pkg::CFG_SETTLE) begin
        sw_cfg_r    <= pin_sync_r[8:3];
        cfg_valid_r <= 1'b1;
      end
    end
  end

  // Setting decode: software mode or switch positions.
  wire       sw_mode  = ctrl_r[scf_pkg::CTRL_SW_MODE];
  wire       dual     = ctrl_r[scf_pkg::CTRL_DUAL];
  wire       falling  = ctrl_r[scf_pkg::CTRL_FALLING];
  wire [2:0] cur_code = sw_cfg_r[2:0];
  wire [1:0] res_code = sw_cfg_r[5:4];
  logic [9:0] eff_res;
  logic [4:0] eff_cur;
  always_comb begin
    eff_res = res_r;
    eff_cur = cur_r;
    if (!sw_mode) begin
      case (res_code)
        2'h1:    eff_res = scf_pkg::RES_SW8;
        2'h2:    eff_res = scf_pkg::RES_SW16;
        2'h3:    eff_res = scf_pkg::RES_SW32;
        default: eff_res = res_r;
      endcase
      case (cur_code)
        3'h1:    eff_cur = 5'h05;
        3'h2:    eff_cur = 5'h07;
        3'h3:    eff_cur = 5'h0A;
        3'h4:    eff_cur = 5'h0D;
        3'h5:    eff_cur = 5'h10;
        3'h6:    eff_cur = 5'h13;
        3'h7:    eff_cur = 5'h16;
        default: eff_cur = cur_r;
      endcase
    end
  end

  // Standstill ratio: switch on keeps full current outside software mode.
  wire [6:0]  eff_pct  = (!sw_mode && !sw_cfg_r[3]) ? scf_pkg::PCT_FULL
                                                     : pct_r;
  wire [11:0] idle_mul = 12'(eff_cur * eff_pct);
  wire [4:0]  idle_cur = 5'(idle_mul / 12'(scf_pkg::PCT_FULL));
  wire        idle     = idle_cnt_r >= idle_ms_cfg_r;
  wire        run      = cfg_valid_r && s_enable && !(|fault_r);
  wire [4:0]  cur_nxt  = !run ? 5'h00 : (idle ? idle_cur : eff_cur);

  // Step decode; direction is sampled at the active edge.
  wire step_ev = act_edge(s_step, edge_prev_r[0], falling);
  wire back_ev = act_edge(s_dir, edge_prev_r[1], falling);
  wire inc     = run && (dual ? (step_ev && !back_ev)
                              : (step_ev && s_dir));
  wire dec     = run && (dual ? (back_ev && !step_ev)
                              : (step_ev && !s_dir));
  wire any_ev  = run && (dual ? (step_ev || back_ev) : step_ev);
  wire ms_tick = pre_r == MS_LAST;

  // Position, idle timer and millisecond prescaler.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_prev_r <= 2'h0;
      position_r  <= 32'h0000_0000;
      pre_r       <= 16'h0000;
      idle_cnt_r  <= 16'h0000;
    end else begin
      edge_prev_r <= {s_dir, s_step};
      pre_r       <= ms_tick ? 16'h0000 : pre_r + 16'h0001;
      if (inc) position_r <= position_r + 32'h0000_0001;
      else if (dec) position_r <= position_r - 32'h0000_0001;
      if (any_ev) idle_cnt_r <= 16'h0000;
      else if (ms_tick && !idle) idle_cnt_r <= idle_cnt_r + 16'h0001;
    end
  end

  // Faults latch until reset; the highest priority one is shown.
  wire [2:0] blink_code = fault_r[0] ? scf_pkg::BLINK_OC :
                          fault_r[1] ? scf_pkg::BLINK_OV :
                          fault_r[2] ? scf_pkg::BLINK_PH :
                                       3'h0;
  wire led_nxt = (|fault_r) && (slot_idx_r < blink_code) &&
                 (slot_ms_r < scf_pkg::FLASH_ON_MS);
  wire frame_end = frame_ms_r == scf_pkg::FRAME_MS - 12'h001;
  wire slot_end  = slot_ms_r == scf_pkg::SLOT_MS - 9'h001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_r    <= 3'h0;
      frame_ms_r <= 12'h000;
      slot_ms_r  <= 9'h000;
      slot_idx_r <= 3'h0;
    end else begin
      fault_r <= fault_r | s_faults;
      if (ms_tick && frame_end) begin
        frame_ms_r <= 12'h000;
        slot_ms_r  <= 9'h000;
        slot_idx_r <= 3'h0;
      end else if (ms_tick) begin
        frame_ms_r <= frame_ms_r + 12'h001;
        slot_ms_r  <= slot_end ? 9'h000 : slot_ms_r + 9'h001;
        if (slot_end) slot_idx_r <= slot_idx_r + 3'h1;
      end
    end
  end

  // Outputs to the power stage and indicator, all registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_active_out  <= 1'b0;
      current_cmd_out   <= 5'h00;
      microstep_res_out <= scf_pkg::RES_RST;
      red_led_out       <= 1'b0;
    end else begin
      drive_active_out  <= run;
      current_cmd_out   <= cur_nxt;
      microstep_res_out <= eff_res;
      red_led_out       <= led_nxt;
    end
  end

  // Write path: address and data are taken in either order.
  wire        do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire        wr_ctrl  = awaddr_r == scf_pkg::ADDR_CTRL;
  wire        wr_res   = awaddr_r == scf_pkg::ADDR_RES;
  wire        wr_cur   = awaddr_r == scf_pkg::ADDR_CUR;
  wire        wr_idle  = awaddr_r == scf_pkg::ADDR_IDLE;
  wire        wr_hit   = wr_ctrl || wr_res || wr_cur || wr_idle;
  wire [31:0] idle_reg = {idle_ms_cfg_r, 9'h000, pct_r};
  wire [31:0] m_ctrl   = merge({29'h0, ctrl_r}, wdata_r, wstrb_r);
  wire [31:0] m_res    = merge({22'h0, res_r}, wdata_r, wstrb_r);
  wire [31:0] m_cur    = merge({27'h0, cur_r}, wdata_r, wstrb_r);
  wire [31:0] m_idle   = merge(idle_reg, wdata_r, wstrb_r);
  wire [9:0]  res_in   = (|m_res[31:10] || m_res[9:0] > scf_pkg::RES_MAX)
                         ? scf_pkg::RES_MAX : m_res[9:0];
  wire [4:0]  cur_in   = (|m_cur[31:5] || m_cur[4:0] > scf_pkg::CUR_MAX)
                         ? scf_pkg::CUR_MAX : m_cur[4:0];
  wire [6:0]  pct_in   = (m_idle[6:0] > scf_pkg::PCT_FULL)
                         ? scf_pkg::PCT_FULL : m_idle[6:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= scf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_hold_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_hold_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Software settings; out-of-range values are clamped to the limits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r        <= 3'h0;
      res_r         <= scf_pkg::RES_RST;
      cur_r         <= scf_pkg::CUR_RST;
      pct_r         <= scf_pkg::PCT_RST;
      idle_ms_cfg_r <= scf_pkg::IDLE_MS_RST;
    end else if (do_write) begin
      if (wr_ctrl) ctrl_r <= m_ctrl[2:0];
      if (wr_res) res_r <= (res_in < scf_pkg::RES_MIN)
                           ? scf_pkg::RES_MIN : res_in;
      if (wr_cur) cur_r <= (cur_in < scf_pkg::CUR_MIN)
                           ? scf_pkg::CUR_MIN : cur_in;
      if (wr_idle) begin
        pct_r         <= pct_in;
        idle_ms_cfg_r <= m_idle[31:16];
      end
    end
  end

  // Read path: one read at a time, data registered with the answer.
  wire [31:0] status = {6'h00, eff_res, eff_cur, 2'h0, blink_code,
                        fault_r, idle, run, cfg_valid_r};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == scf_pkg::ADDR_CTRL) rd_mux = {29'h0, ctrl_r};
    else if (s_axi_araddr == scf_pkg::ADDR_RES) rd_mux = {22'h0, res_r};
    else if (s_axi_araddr == scf_pkg::ADDR_CUR) rd_mux = {27'h0, cur_r};
    else if (s_axi_araddr == scf_pkg::ADDR_IDLE) rd_mux = idle_reg;
    else if (s_axi_araddr == scf_pkg::ADDR_STATUS) rd_mux = status;
    else if (s_axi_araddr == scf_pkg::ADDR_POS) rd_mux = position_r;
    else begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= scf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fault_stays_latched: assert property (
    (fault_r & $past(fault_r)) == $past(fault_r))
    else $error("latched fault cleared without reset");
  a_fault_frees_shaft: assert property (
    |fault_r |=> !drive_active_out ##1 !drive_active_out)
    else $error("drive active while fault latched");
  a_led_dark_no_fault: assert property (
    fault_r == 3'h0 |=> !red_led_out)
    else $error("indicator lit with no fault");
  a_oc_wins_priority: assert property (
    fault_r[0] |-> blink_code == 3'h1)
    else $error("over-current not shown first");
  a_ov_two_flashes: assert property (
    fault_r[1] && !fault_r[0] |-> blink_code == 3'h2)
    else $error("over-voltage blink count wrong");
  a_step_moves_one: assert property (
    inc |=> position_r == $past(position_r) + 32'h0000_0001)
    else $error("position not advanced by one");
  a_busy_full_current: assert property (
    any_ev && |idle_ms_cfg_r ##1 run |=> current_cmd_out == $past(eff_cur))
    else $error("current reduced right after a step");
  a_res_switch_eight: assert property (
    cfg_valid_r && !sw_mode && res_code == 2'h1 |=>
    microstep_res_out == 10'h008)
    else $error("switch resolution 8 not applied");
  a_no_step_early: assert property (
    !cfg_valid_r |=> $stable(position_r))
    else $error("step taken before configuration");

  c_fault_shown: cover property (fault_r != 3'h0 ##1 red_led_out);
  c_idle_entered: cover property (run && !idle ##1 idle);
  c_dual_back: cover property (dual && dec);
endmodule

// >>> scf_motion_ctrl.sv
`timescale 1ns/1ns
// Pulse generator on the controller side; it changes pins after a clock edge.
module scf_motion_ctrl (
  input  wire logic aclk,            // Bench clock, 40 ns.
  output logic      step_pulse_in,   // Step pulse to the drive.
  output logic      direction_in,    // Direction level to the drive.
  output logic      drive_enable_in  // Enable level to the drive.
);
  localparam int LEAD_CYC = 125;  // Five microseconds at 40 ns.
  localparam int HALF_CYC = 188;  // 7.5 us, rounded up so it is never short.

  // An unconnected enable reads high, so the model starts enabled.
  initial begin
    step_pulse_in   = 1'b0;
    direction_in    = 1'b0;
    drive_enable_in = 1'b1;
  end

  // Enable leads any later direction change by the full lead time.
  task automatic set_enable(input logic en);
    @(posedge aclk);
    drive_enable_in <= en;
    repeat (LEAD_CYC) @(posedge aclk);
  endtask

  // Each pulse sets direction first, then a high and a low phase.
  task automatic pulse(input logic up, input int n);
    for (int k = 0; k < n; k++) begin
      direction_in <= up;
      repeat (LEAD_CYC) @(posedge aclk);
      step_pulse_in <= 1'b1;
      repeat (HALF_CYC) @(posedge aclk);
      step_pulse_in <= 1'b0;
      repeat (HALF_CYC) @(posedge aclk);
    end
  endtask
endmodule

// >>> tb_stepper_config_fault_indicator.sv
`timescale 1ns/1ns
module tb_stepper_config_fault_indicator;
  localparam int MS  = 25;  // Short millisecond keeps the fault frame cheap.
  localparam int FRM = MS * scf_pkg::FRAME_S * scf_pkg::MS_PER_S;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0]  rs;
  logic        step_pulse_in, direction_in, drive_enable_in;
  logic [5:0]  sw = 6'h00;  // Current [2:0], standstill [3], resolution [5:4].
  logic        over_current_in = 1'b0;
  logic        over_voltage_in = 1'b0;
  logic        phase_error_in = 1'b0;
  logic        drive_active_out, red_led_out, led_q;
  logic [4:0]  current_cmd_out;
  logic [9:0]  microstep_res_out;
  int          errors = 0;
  int          tests_run = 0;
  int          blinks;
  logic [9:0]  res_tab [4] = '{10'h080, 10'h008, 10'h010, 10'h020};
  logic [4:0]  cur_tab [8] = '{5'h0A, 5'h05, 5'h07, 5'h0A,
                               5'h0D, 5'h10, 5'h13, 5'h16};

  scf_drive_ctrl #(.MS_CYCLES(MS)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .step_pulse_in, .direction_in,
    .drive_enable_in, .current_select_bit0(sw[0]),
    .current_select_bit1(sw[1]), .current_select_bit2(sw[2]),
    .standstill_current_select(sw[3]), .resolution_select_bit0(sw[4]),
    .resolution_select_bit1(sw[5]), .over_current_in, .over_voltage_in,
    .phase_error_in, .drive_active_out, .current_cmd_out,
    .microstep_res_out, .red_led_out);
  scf_motion_ctrl ctl (.aclk, .step_pulse_in, .direction_in,
    .drive_enable_in);

  always #20 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  // Switches are sampled only after release, so each setting needs a reset.
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask

  // Address and data are released separately, each at its own handshake.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // The fault frame dominates the run; the limit leaves room for the rest.
  initial begin
    repeat (FRM + 20000) @(posedge aclk);
    errors++;
    wrap_up();
  end

  initial begin
    do_reset();
    axi_rd(scf_pkg::ADDR_CTRL);
    chk("ctrl after reset", 32'h0, rd);
    axi_rd(scf_pkg::ADDR_IDLE);
    chk("idle after reset", 32'h07D0_003C, rd);
    axi_rd(8'h20);
    chk("unmapped read resp", 32'(scf_pkg::RESP_SLVERR), 32'(rs));
    axi_wr(scf_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    chk("status write resp", 32'(scf_pkg::RESP_SLVERR), 32'(rs));
    for (int i = 0; i < 8; i++) begin
      sw <= {i[1:0], 1'b0, i[2:0]};
      do_reset();
      chk("resolution", 32'(res_tab[i % 4]), 32'(microstep_res_out));
      chk("current", 32'(cur_tab[i]), 32'(current_cmd_out));
    end
    axi_wr(scf_pkg::ADDR_IDLE, 32'h0001_0032);
    repeat (200) @(posedge aclk);
    chk("standstill full", 32'h16, 32'(current_cmd_out));
    sw <= 6'h3F;
    do_reset();
    axi_wr(scf_pkg::ADDR_IDLE, 32'h0001_0032);
    repeat (200) @(posedge aclk);
    chk("standstill cut", 32'h0B, 32'(current_cmd_out));
    do_reset();
    axi_wr(scf_pkg::ADDR_CTRL, 32'h1);
    axi_wr(scf_pkg::ADDR_RES, 32'h7D0);
    axi_wr(scf_pkg::ADDR_CUR, 32'h1);
    repeat (8) @(posedge aclk);
    chk("sw resolution", 32'h200, 32'(microstep_res_out));
    chk("sw current", 32'h3, 32'(current_cmd_out));
    axi_wr(scf_pkg::ADDR_RES, 32'h300);
    axi_rd(scf_pkg::ADDR_RES);
    chk("res clamp", 32'h200, rd);
    ctl.pulse(1'b1, 2);
    ctl.pulse(1'b0, 1);
    axi_rd(scf_pkg::ADDR_POS);
    chk("position", 32'h1, rd);
    ctl.set_enable(1'b0);
    chk("drive off", 32'h0, 32'(drive_active_out));
    ctl.pulse(1'b1, 1);
    ctl.set_enable(1'b1);
    chk("drive on", 32'h1, 32'(drive_active_out));
    axi_rd(scf_pkg::ADDR_POS);
    chk("position held", 32'h1, rd);
    // Dual mode counts a direction edge back; then falling step/direction.
    axi_wr(scf_pkg::ADDR_CTRL, 32'h3);
    ctl.pulse(1'b0, 1);
    ctl.pulse(1'b1, 1);
    axi_rd(scf_pkg::ADDR_POS);
    chk("dual position", 32'h2, rd);
    axi_wr(scf_pkg::ADDR_CTRL, 32'h5);
    ctl.pulse(1'b0, 1);
    axi_rd(scf_pkg::ADDR_POS);
    chk("falling position", 32'h1, rd);
    phase_error_in <= 1'b1;
    repeat (10) @(posedge aclk);
    phase_error_in <= 1'b0;
    chk("fault frees shaft", 32'h0, 32'(drive_active_out));
    blinks = 0;
    led_q = red_led_out;
    repeat (FRM) begin
      @(posedge aclk);
      if (red_led_out && !led_q)
        blinks++;
      led_q = red_led_out;
    end
    chk("phase blinks", 32'h4, 32'(blinks));
    over_voltage_in <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_rd(scf_pkg::ADDR_STATUS);
    chk("voltage blinks", 32'h2, 32'(rd[8:6]));
    chk("status res", 32'h200, 32'(rd[25:16]));
    over_current_in <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_rd(scf_pkg::ADDR_STATUS);
    chk("current blinks", 32'h1, 32'(rd[8:6]));
    over_current_in <= 1'b0;
    over_voltage_in <= 1'b0;
    repeat (10) @(posedge aclk);
    axi_rd(scf_pkg::ADDR_STATUS);
    chk("faults latched", 32'h7, 32'(rd[5:3]));
    chk("drive stays off", 32'h0, 32'(drive_active_out));
    wrap_up();
  end
endmodule
